//--- rx_status_flags.sv
// Serial receiver with its status flags, buffers and Avalon-MM register slave.
// Summary of operation
// - Fault summary flag is the OR of break, stop fault, overwrite, parity flags.
// - Fault interrupt is raised while summary flag and fault interrupt enable are set.
// - Summary flag cannot be cleared directly; only reinit, system reset or clearing parity enable with parity as its only fault clear it.
// - New character in holding buffer sets char available; interrupt if enabled.
// - Char available clears on buffer read, active reinit or system reset.
// - Break flag sets after ten bit times low following a missing stop bit.
// - Break requests receive interrupt if enabled and loads nothing into the buffer; with sleep clear its frame is loaded at the missing stop bit.
// - Break interrupt works even while the receiver sleep bit is set.
// - Break flag stays set when characters follow; only reinit or reset clear it.
// - Stop bit fault flag sets when the expected stop bit is missing.
// - Only the first stop bit is checked; further stop bits are ignored.
// - Stop bit fault flag clears on active reinit or system reset.
// - Char, overwrite and parity flags update when a character enters the holding buffer and debug view.
// - Overwrite flag sets when a character arrives before the previous was read.
// - Parity flag sets on mismatch including address bit; reads 0 with parity off.
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module rx_status_flags #(
  parameter int CYCLES_PER_BIT = rx_status_pkg::DEFAULT_CYCLES_PER_BIT
) (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [3:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  input wire logic serial_input_line, // Asynchronous receive pin
  output logic rx_irq, // Character or break interrupt request
  output logic fault_irq // Receive fault interrupt request
);
  localparam logic [15:0] BIT_CNT = 16'(CYCLES_PER_BIT - 1);
  localparam logic [15:0] HALF_CNT = 16'(CYCLES_PER_BIT / 2 - 1);

  logic ack, next_ack;
  logic [31:0] next_readdata;
  logic [6:0] ctrl, next_ctrl;
  logic rx_meta, rx_s;
  rx_status_pkg::rx_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [3:0] nbits, next_nbits;
  logic [8:0] shreg, next_shreg;
  logic pbit, next_pbit;
  logic [7:0] receive_holding_buffer, next_hold;
  logic char_available_flag, next_char;
  logic line_break_flag, next_break;
  logic stop_bit_fault_flag, next_stop;
  logic overwrite_fault_flag, next_over;
  logic parity_raw, next_parity;
  logic transfer, reinit, tick, buf_read, parity_bad, last_bit;
  logic parity_mismatch_flag, summary;
  logic [7:0] receive_status_reg;

  // Reinit is active while the control bit is 0, as after reset.
  assign reinit = ~ctrl[rx_status_pkg::CTRL_SOFT_REINIT];
  assign parity_mismatch_flag = parity_raw & ctrl[rx_status_pkg::CTRL_PARITY_EN];
  assign summary = line_break_flag | stop_bit_fault_flag | overwrite_fault_flag
    | parity_mismatch_flag;
  assign receive_status_reg = {summary, char_available_flag, line_break_flag,
    stop_bit_fault_flag, overwrite_fault_flag, parity_mismatch_flag, 2'b00};
  assign fault_irq = summary & ctrl[rx_status_pkg::CTRL_FAULT_IRQ_EN];
  assign rx_irq = (char_available_flag | line_break_flag)
    & ctrl[rx_status_pkg::CTRL_CHAR_IRQ_EN];
  assign waitrequest = (read | write) & ~ack;
  assign buf_read = read & ack & (address == rx_status_pkg::HOLD_OFFSET);

  // Bus slave: one wait cycle, then the answer; the control register is the only writable one.
  always_comb begin
    next_ack = (read | write) & ~ack;
    next_readdata = readdata;
    next_ctrl = ctrl;
    if (read & ~ack) begin
      case (address)
        rx_status_pkg::CTRL_OFFSET: next_readdata = {25'h0000000, ctrl};
        rx_status_pkg::STATUS_OFFSET: next_readdata = {24'h000000, receive_status_reg};
        rx_status_pkg::HOLD_OFFSET: next_readdata = {24'h000000, receive_holding_buffer};
        rx_status_pkg::DEBUG_OFFSET: next_readdata = {24'h000000, receive_holding_buffer};
        default: next_readdata = 32'h00000000;
      endcase
    end
    // Writes to the status and buffer offsets fall through with no effect.
    if (write & ack & (address == rx_status_pkg::CTRL_OFFSET)) begin
      next_ctrl = writedata[6:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
      readdata <= 32'h00000000;
      ctrl <= rx_status_pkg::CTRL_RESET;
    end else begin
      ack <= next_ack;
      readdata <= next_readdata;
      ctrl <= next_ctrl;
    end
  end

  // Two-stage synchroniser on the receive pin; only rx_s is read by logic.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_meta <= serial_input_line;
      rx_s <= rx_meta;
    end
  end

  assign tick = (cnt == 16'h0000);
  assign last_bit = ctrl[rx_status_pkg::CTRL_ADDR_MODE] ? (nbits == 4'h8) : (nbits == 4'h7);
  assign transfer = (state == rx_status_pkg::RX_STOP) & tick & ~reinit
    & ~ctrl[rx_status_pkg::CTRL_SLEEP];
  // The address bit, when present, takes part in the parity count.
  assign parity_bad = ((^shreg[7:0]) ^ (ctrl[rx_status_pkg::CTRL_ADDR_MODE] & shreg[8]) ^ pbit)
    ^ ~ctrl[rx_status_pkg::CTRL_PARITY_EVEN];

  // Receiver sequence and flags; a hardware set beats a buffer-read clear.
  always_comb begin
    next_state = state;
    next_cnt = tick ? 16'h0000 : cnt - 16'h0001;
    next_nbits = nbits;
    next_shreg = shreg;
    next_pbit = pbit;
    next_hold = receive_holding_buffer;
    next_char = char_available_flag & ~buf_read;
    next_break = line_break_flag;
    next_stop = stop_bit_fault_flag;
    next_over = overwrite_fault_flag;
    next_parity = parity_raw;
    case (state)
      rx_status_pkg::RX_IDLE: begin
        if (!rx_s) begin
          next_state = rx_status_pkg::RX_START;
          next_cnt = HALF_CNT;
        end
      end
      rx_status_pkg::RX_START: begin
        if (tick) begin
          next_state = rx_s ? rx_status_pkg::RX_IDLE : rx_status_pkg::RX_DATA;
          next_cnt = BIT_CNT;
          next_nbits = 4'h0;
          next_shreg = 9'h000;
        end
      end
      rx_status_pkg::RX_DATA: begin
        if (tick) begin
          next_shreg[nbits] = rx_s;
          next_nbits = nbits + 4'h1;
          next_cnt = BIT_CNT;
          if (last_bit) begin
            next_state = ctrl[rx_status_pkg::CTRL_PARITY_EN] ? rx_status_pkg::RX_PAR
              : rx_status_pkg::RX_STOP;
          end
        end
      end
      rx_status_pkg::RX_PAR: begin
        if (tick) begin
          next_pbit = rx_s;
          next_cnt = BIT_CNT;
          next_state = rx_status_pkg::RX_STOP;
        end
      end
      rx_status_pkg::RX_STOP: begin
        // Only the first stop bit is sampled; the line is free again right after.
        if (tick) begin
          next_cnt = BIT_CNT;
          next_nbits = 4'h0;
          next_state = rx_s ? rx_status_pkg::RX_IDLE : rx_status_pkg::RX_BREAK;
          if (!rx_s) begin
            next_stop = 1'b1;
          end
          if (transfer) begin
            next_hold = shreg[7:0];
            next_char = 1'b1;
            next_over = overwrite_fault_flag | char_available_flag;
            next_parity = parity_raw
              | (ctrl[rx_status_pkg::CTRL_PARITY_EN] & parity_bad);
          end
        end
      end
      rx_status_pkg::RX_BREAK: begin
        // Any high sample ends the break watch; ten low bit times flag it.
        if (rx_s) begin
          next_state = rx_status_pkg::RX_IDLE;
        end else if (tick) begin
          next_cnt = BIT_CNT;
          next_nbits = nbits + 4'h1;
          if (nbits == rx_status_pkg::BREAK_BITS - 4'h1) begin
            next_break = 1'b1;
            next_state = rx_status_pkg::RX_HALT;
          end
        end
      end
      rx_status_pkg::RX_HALT: begin
        // Receiver stays parked after a break until reinit.
        next_state = rx_status_pkg::RX_HALT;
      end
      default: next_state = rx_status_pkg::RX_IDLE;
    endcase
    if (reinit) begin
      next_state = rx_status_pkg::RX_IDLE;
      next_char = 1'b0;
      next_break = 1'b0;
      next_stop = 1'b0;
      next_over = 1'b0;
      next_parity = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= rx_status_pkg::RX_IDLE;
      cnt <= 16'h0000;
      nbits <= 4'h0;
      shreg <= 9'h000;
      pbit <= 1'b0;
      receive_holding_buffer <= 8'h00;
      char_available_flag <= 1'b0;
      line_break_flag <= 1'b0;
      stop_bit_fault_flag <= 1'b0;
      overwrite_fault_flag <= 1'b0;
      parity_raw <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      nbits <= next_nbits;
      shreg <= next_shreg;
      pbit <= next_pbit;
      receive_holding_buffer <= next_hold;
      char_available_flag <= next_char;
      line_break_flag <= next_break;
      stop_bit_fault_flag <= next_stop;
      overwrite_fault_flag <= next_over;
      parity_raw <= next_parity;
    end
  end

  AST_SUMMARY_OR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    receive_status_reg[7] == (|receive_status_reg[5:2]))
    else $error("summary flag differs from OR of fault flags");
  AST_FAULT_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fault_irq == ((|receive_status_reg[5:2]) && ctrl[rx_status_pkg::CTRL_FAULT_IRQ_EN]))
    else $error("fault interrupt missing");
  AST_SUMMARY_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (summary && !reinit && next_ctrl[rx_status_pkg::CTRL_SOFT_REINIT]) |=> summary)
    else $error("summary flag cleared without reinit");
  AST_CHAR_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    transfer |=> char_available_flag && receive_holding_buffer == $past(shreg[7:0]))
    else $error("character not made available");
  AST_CHAR_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (buf_read && !transfer) |=> !char_available_flag)
    else $error("buffer read did not clear char flag");
  AST_BREAK_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(line_break_flag) |-> $past(state) == rx_status_pkg::RX_BREAK
      && $past(nbits) == 4'h9 && $past(tick))
    else $error("break flag set without ten low bits");
  AST_BREAK_NOLOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(line_break_flag) |-> $stable(receive_holding_buffer) && !$rose(char_available_flag))
    else $error("break loaded the holding buffer");
  AST_BREAK_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (line_break_flag && ctrl[rx_status_pkg::CTRL_CHAR_IRQ_EN]) |-> rx_irq)
    else $error("break interrupt missing");
  AST_BREAK_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (line_break_flag && ctrl[0] && next_ctrl[0]) |=> line_break_flag)
    else $error("break flag dropped without reinit");
  AST_STOP_FAULT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == rx_status_pkg::RX_STOP && tick && !rx_s && !reinit) |=> stop_bit_fault_flag)
    else $error("missing stop bit not flagged");
  AST_REINIT_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reinit |=> receive_status_reg[6:2] == 5'h00)
    else $error("reinit did not clear flags");
  AST_OVERWRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (transfer && char_available_flag && !buf_read) |=> overwrite_fault_flag)
    else $error("overwrite not flagged");
  AST_PARITY_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !ctrl[rx_status_pkg::CTRL_PARITY_EN] |-> !receive_status_reg[2])
    else $error("parity flag visible while parity is off");
  AST_STATUS_RO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (write && ack && address == rx_status_pkg::STATUS_OFFSET && state != rx_status_pkg::RX_STOP
      && state != rx_status_pkg::RX_BREAK && !reinit) |=> $stable(receive_status_reg[5:2]))
    else $error("status write changed a flag");
  AST_FIRST_STOP_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == rx_status_pkg::RX_STOP && tick && rx_s) |=> state == rx_status_pkg::RX_IDLE)
    else $error("receiver waited on a further stop bit");
  AST_BREAK_PARKS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == rx_status_pkg::RX_HALT && !reinit) |=> state == rx_status_pkg::RX_HALT)
    else $error("receiver left the parked state without reinit");
  AST_DEBUG_VIEW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (read && !ack && address == rx_status_pkg::DEBUG_OFFSET)
      |=> readdata == {24'h000000, $past(receive_holding_buffer)})
    else $error("debug view differs from holding buffer");
  AST_PARITY_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (transfer && ctrl[rx_status_pkg::CTRL_PARITY_EN] && parity_bad) |=> parity_raw)
    else $error("parity mismatch not flagged");
  // Covers for the main scenarios; the bench never reads the buffer within 20 cycles of a transfer, so COV_CHAR is not hit.
  COV_CHAR: cover property (@(posedge ref_clk) disable iff (!rst_n) transfer ##[1:20] buf_read);
  COV_BREAK: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(line_break_flag));
  COV_OVERRUN: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(overwrite_fault_flag));
  COV_PARITY: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(parity_raw));
  COV_SLEEP_BREAK: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(line_break_flag) && ctrl[rx_status_pkg::CTRL_SLEEP]);
endmodule

//--- rx_status_pkg.sv
// Constants for the receiver status flag block: register map, field positions and counts.
package rx_status_pkg;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] HOLD_OFFSET = 4'h8;
  localparam logic [3:0] DEBUG_OFFSET = 4'hC;
  localparam int CTRL_SOFT_REINIT = 0;
  localparam int CTRL_FAULT_IRQ_EN = 1;
  localparam int CTRL_CHAR_IRQ_EN = 2;
  localparam int CTRL_PARITY_EN = 3;
  localparam int CTRL_PARITY_EVEN = 4;
  localparam int CTRL_ADDR_MODE = 5;
  localparam int CTRL_SLEEP = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int ST_SUMMARY = 7;
  localparam int ST_CHAR = 6;
  localparam int ST_BREAK = 5;
  localparam int ST_STOP_FAULT = 4;
  localparam int ST_OVERWRITE = 3;
  localparam int ST_PARITY = 2;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  localparam int DEFAULT_CYCLES_PER_BIT = 1736;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_PAR = 3'h3,
    RX_STOP = 3'h4,
    RX_BREAK = 3'h5,
    RX_HALT = 3'h6
  } rx_state_t;
endpackage

//--- serial_tx_model.sv
// Remote asynchronous transmitter that drives the receive line of the status block.
`timescale 1ns/1ps
module serial_tx_model #(
  parameter int CYCLES_PER_BIT = 16
) (
  input wire logic ref_clk, // Bit timing reference
  output logic serial_input_line // Receive line, idles high
);
  initial serial_input_line = 1'b1;

  task automatic hold_bit(input logic v);
    serial_input_line <= v;
    repeat (CYCLES_PER_BIT) @(posedge ref_clk);
  endtask

  // Sends start, eight data bits LSB first, optional parity and one stop bit.
  // A low stop bit with ten or more extra low bits after it forms a break.
  task automatic send(input logic [7:0] d, input logic use_par, input logic par,
                      input logic stop, input int low_bits);
    @(posedge ref_clk);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++) hold_bit(d[i]);
    if (use_par) hold_bit(par);
    hold_bit(stop);
    repeat (low_bits) hold_bit(1'b0);
    hold_bit(1'b1);
  endtask

  // Sends a whole frame given bit by bit, start bit first, then idles for one bit.
  task automatic send_raw(input logic [11:0] bits, input int n);
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) hold_bit(bits[i]);
    hold_bit(1'b1);
  endtask
endmodule

//--- uart_receiver_status_flags_bench.sv
// Self-checking bench for the receiver status flag block.
`timescale 1ns/1ps
module uart_receiver_status_flags_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic serial_input_line;
  logic rx_irq;
  logic fault_irq;
  logic [31:0] st;
  int miscompares = 0;
  int comparisons = 0;

  always #2.5 ref_clk = ~ref_clk;

  serial_tx_model #(.CYCLES_PER_BIT(16)) tx (
    .ref_clk(ref_clk), .serial_input_line(serial_input_line));

  rx_status_flags #(.CYCLES_PER_BIT(16)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .serial_input_line(serial_input_line), .rx_irq(rx_irq), .fault_irq(fault_irq));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  // The request stays up until the edge at which waitrequest is seen low.
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check(32'h1, 32'h0);
    write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check(32'h1, 32'h0);
    d = readdata;
    read <= 1'b0;
  endtask

  task automatic status_is(input logic [31:0] exp);
    bus_rd(rx_status_pkg::STATUS_OFFSET, st);
    check(st, exp);
  endtask

  task automatic reinit(input logic [31:0] ctrl);
    bus_wr(rx_status_pkg::CTRL_OFFSET, 32'h0);
    bus_wr(rx_status_pkg::CTRL_OFFSET, ctrl);
  endtask

  task automatic test_char;
    reinit(32'h05);
    tx.send(8'h5A, 1'b0, 1'b0, 1'b1, 0);
    status_is(32'h40);
    check({31'h0, rx_irq}, 32'h1);
    bus_wr(rx_status_pkg::STATUS_OFFSET, 32'hFF);
    status_is(32'h40);
    bus_rd(rx_status_pkg::DEBUG_OFFSET, st);
    check(st, 32'h5A);
    status_is(32'h40);
    bus_rd(rx_status_pkg::HOLD_OFFSET, st);
    check(st, 32'h5A);
    status_is(32'h00);
    check({31'h0, rx_irq}, 32'h0);
    $display("test_char done");
  endtask

  task automatic test_overwrite;
    reinit(32'h07);
    tx.send(8'h5A, 1'b0, 1'b0, 1'b1, 0);
    tx.send(8'hA5, 1'b0, 1'b0, 1'b1, 0);
    status_is(32'hC8);
    check({31'h0, fault_irq}, 32'h1);
    bus_rd(rx_status_pkg::HOLD_OFFSET, st);
    check(st, 32'hA5);
    status_is(32'h88);
    reinit(32'h07);
    status_is(32'h00);
    check({31'h0, fault_irq}, 32'h0);
    $display("test_overwrite done");
  endtask

  task automatic test_parity;
    reinit(32'h1D);
    tx.send(8'h5A, 1'b1, 1'b1, 1'b1, 0);
    status_is(32'hC4);
    check({31'h0, fault_irq}, 32'h0);
    $display("test_parity done");
  endtask

  task automatic test_frame;
    reinit(32'h05);
    // Nine low bits after the stop bit stay short of ten bit times, so no break.
    tx.send(8'h33, 1'b0, 1'b0, 1'b0, 9);
    status_is(32'hD0);
    reinit(32'h05);
    status_is(32'h00);
    $display("test_frame done");
  endtask

  task automatic test_break;
    reinit(32'h45);
    tx.send(8'h00, 1'b0, 1'b0, 1'b0, 12);
    status_is(32'hB0);
    check({31'h0, rx_irq}, 32'h1);
    bus_wr(rx_status_pkg::CTRL_OFFSET, 32'h05);
    tx.send(8'h66, 1'b0, 1'b0, 1'b1, 0);
    status_is(32'hB0);
    check({31'h0, st[5]}, 32'h1);
    reinit(32'h05);
    status_is(32'h00);
    tx.send(8'h66, 1'b0, 1'b0, 1'b1, 0);
    status_is(32'h40);
    $display("test_break done");
  endtask

  // Odd parity in address-bit mode: the address bit counts towards parity.
  task automatic test_addr_parity;
    reinit(32'h2D);
    tx.send_raw({1'b1, 1'b0, 1'b1, 8'h5A, 1'b0}, 12);
    status_is(32'h40);
    bus_rd(rx_status_pkg::HOLD_OFFSET, st);
    check(st, 32'h5A);
    tx.send_raw({1'b1, 1'b0, 1'b0, 8'h5A, 1'b0}, 12);
    status_is(32'hC4);
    $display("test_addr_parity done");
  endtask

  task automatic test_sysreset;
    reinit(32'h07);
    tx.send(8'h33, 1'b0, 1'b0, 1'b0, 0);
    status_is(32'hD0);
    check({31'h0, fault_irq}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    status_is(32'h00);
    check({30'h0, rx_irq, fault_irq}, 32'h0);
    bus_rd(rx_status_pkg::CTRL_OFFSET, st);
    check(st, 32'h00);
    $display("test_sysreset done");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    status_is(32'h00);
    check({30'h0, rx_irq, fault_irq}, 32'h0);
    test_char();
    test_overwrite();
    test_parity();
    test_frame();
    test_break();
    test_addr_parity();
    test_sysreset();
    give_verdict();
  end
endmodule
